//--- src/flash_host_pkg.sv
// Purpose: shared constants and types of the flash host controller
// Assumes: 100 MHz clk, 16-bit flash data bus, x8 or x16 strap
// Notes: command codes are the byte values written on the low data lane
package flash_host_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_NS = 10;
    localparam int TICK_NS = 20;
    localparam int TICK_CYCLES = (TICK_NS + CLK_NS - 1) / CLK_NS;
    localparam int STROBE_NS = 100;
    localparam int STROBE_TICKS = (STROBE_NS + TICK_NS - 1) / TICK_NS;

    // ----------------------------------------------------------------
    // command codes
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
    localparam logic [7:0] CMD_READ_ID = 8'h90;
    localparam logic [7:0] CMD_READ_QUERY = 8'h98;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_BUF_WRITE = 8'he8;
    localparam logic [7:0] CMD_PROGRAM = 8'h40;
    localparam logic [7:0] CMD_PROGRAM_ALT = 8'h10;
    localparam logic [7:0] CMD_BLOCK_ERASE = 8'h20;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h30;
    localparam logic [7:0] CMD_SUSPEND = 8'hb0;
    localparam logic [7:0] CMD_CONFIRM = 8'hd0;
    localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
    localparam logic [7:0] CMD_LOCK_SET = 8'h01;

    // ----------------------------------------------------------------
    // query table and status layout
    // ----------------------------------------------------------------
    localparam logic [7:0] QUERY_BASE = 8'h10;
    localparam int READY_BIT = 7;
    localparam logic [2:0] STEP_POLL = 3'h7;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_READ = 4'h0, OP_READ_ARRAY = 4'h1, OP_READ_ID = 4'h2, OP_QUERY = 4'h3,
        OP_READ_STATUS = 4'h4, OP_CLEAR_STATUS = 4'h5, OP_PROGRAM = 4'h6,
        OP_BUF_WRITE = 4'h7, OP_BLOCK_ERASE = 4'h8, OP_CHIP_ERASE = 4'h9,
        OP_SUSPEND = 4'ha, OP_RESUME = 4'hb, OP_SET_LOCK = 4'hc, OP_CLEAR_LOCKS = 4'hd
    } op_type;

    typedef enum logic [1:0] {
        MODE_ARRAY = 2'h0, MODE_ID = 2'h1, MODE_QUERY = 2'h2, MODE_STATUS = 2'h3
    } mode_type;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001, ST_ISSUE = 4'b0010, ST_WAIT = 4'b0100, ST_DONE = 4'b1000
    } st_type;

    typedef enum logic [3:0] {
        E_IDLE = 4'b0001, E_SETUP = 4'b0010, E_STROBE = 4'b0100, E_HOLD = 4'b1000
    } eng_type;

    localparam mode_type RESET_MODE = MODE_ARRAY;

endpackage : flash_host_pkg

//--- src/bus_cycle_if.sv
// Purpose: one flash bus cycle request between sequencer and pin engine
// Assumes: req is a one-cycle pulse taken only while the engine is idle
// Notes: rdata is valid when done pulses
`timescale 1ns/100ps
interface bus_cycle_if #(parameter int ADDR_W = 22) ();
    logic req;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [15:0] data;
    logic done;
    logic [15:0] rdata;

    modport ctrl (output req, output write, output addr, output data,
                  input done, input rdata);
    modport engine (input req, input write, input addr, input data,
                    output done, output rdata);
endinterface : bus_cycle_if

//--- src/flash_bus_cycle.sv
// Purpose: drives one read or write strobe cycle on the flash pins
// Assumes: dq_in is asynchronous to clk
// Notes: setup tick, strobe of STROBE_TICKS ticks, hold tick
`timescale 1ns/100ps
module flash_bus_cycle
    import flash_host_pkg::*;
#(
    parameter int ADDR_W = 22
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // request side
    bus_cycle_if.engine bus,
    // flash pins
    input wire logic [15:0] dq_in,
    output logic [ADDR_W-1:0] pin_addr,
    output logic [15:0] pin_dq_out,
    output logic pin_dq_oe_n,
    output logic pin_ce_n,
    output logic pin_rd_n,
    output logic pin_we_n
);

    eng_type state_r;
    logic [7:0] div_r;
    logic [7:0] tick_cnt_r;
    logic write_r;
    logic [15:0] dq_meta_r;
    logic [15:0] dq_sync_r;
    wire tick = (div_r == 8'(TICK_CYCLES - 1));
    wire strobe_last = (tick_cnt_r == 8'(STROBE_TICKS - 1));

    // ----------------------------------------------------------------
    // divider and input synchroniser
    // ----------------------------------------------------------------
    // free running tick enable
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            div_r <= 8'h00;
            dq_meta_r <= 16'h0000;
            dq_sync_r <= 16'h0000;
        end else begin
            div_r <= tick ? 8'h00 : div_r + 8'h01;
            dq_meta_r <= dq_in;
            dq_sync_r <= dq_meta_r;
        end
    end

    // ----------------------------------------------------------------
    // cycle sequencer
    // ----------------------------------------------------------------
    // data held past rising strobe
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r <= E_IDLE;
            tick_cnt_r <= 8'h00;
            write_r <= 1'b0;
            pin_addr <= '0;
            pin_dq_out <= 16'h0000;
            pin_dq_oe_n <= 1'b1;
            pin_ce_n <= 1'b1;
            pin_rd_n <= 1'b1;
            pin_we_n <= 1'b1;
            bus.done <= 1'b0;
            bus.rdata <= 16'h0000;
        end else begin
            bus.done <= 1'b0;
            case (state_r)
                E_IDLE: begin
                    if (bus.req) begin
                        pin_addr <= bus.addr;
                        pin_dq_out <= bus.data;
                        write_r <= bus.write;
                        pin_ce_n <= 1'b0;
                        pin_dq_oe_n <= !bus.write;
                        state_r <= E_SETUP;
                    end
                end
                E_SETUP: begin
                    if (tick) begin
                        pin_we_n <= !write_r;
                        pin_rd_n <= write_r;
                        tick_cnt_r <= 8'h00;
                        state_r <= E_STROBE;
                    end
                end
                E_STROBE: begin
                    if (tick && strobe_last) begin
                        pin_we_n <= 1'b1;
                        pin_rd_n <= 1'b1;
                        bus.rdata <= dq_sync_r;
                        state_r <= E_HOLD;
                    end else if (tick) begin
                        tick_cnt_r <= tick_cnt_r + 8'h01;
                    end
                end
                E_HOLD: begin
                    if (tick) begin
                        pin_ce_n <= 1'b1;
                        pin_dq_oe_n <= 1'b1;
                        bus.done <= 1'b1;
                        state_r <= E_IDLE;
                    end
                end
                default: state_r <= E_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_data_at_rise: assert property (
        @(posedge clk) disable iff (reset)
        $rose(pin_we_n) |-> !pin_dq_oe_n ##1 !pin_dq_oe_n)
        else $error("write data not held across rising write strobe");

    a_strobe_width: assert property (
        @(posedge clk) disable iff (reset)
        $fell(pin_we_n) |-> !pin_we_n [*8])
        else $error("write strobe shorter than eight cycles");

    a_no_overlap: assert property (
        @(posedge clk) disable iff (reset)
        !(!pin_we_n && !pin_rd_n))
        else $error("read and write strobes low together");

endmodule : flash_bus_cycle

//--- src/flash_host_ctrl.sv
// Purpose: host controller that sequences command cycles to a parallel flash
// Assumes: user holds cmd_* stable while cmd_valid, and cmd_data until data_take
// Notes: addresses are in the native unit of the strapped bus width
//
// How it works
// - count, N+1 data writes, then confirm
// - read extended status until buffer ready
// - refuse counts crossing the buffer boundary
// - command cycles write only a defined code or the buffer count
// - x8 mode drives the low address bit low on query reads
// - operations start with command writes, except OP_READ, a repeated ID or query read, read array in array mode, and a refused buffer write
`timescale 1ns/100ps
module flash_host_ctrl
    import flash_host_pkg::*;
#(
    parameter int ADDR_W = 22,
    parameter int BUF_WORDS = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // user command port
    input wire logic cmd_valid,
    input wire op_type cmd_op,
    input wire logic [ADDR_W-1:0] cmd_addr,
    input wire logic [15:0] cmd_data,
    input wire logic [7:0] cmd_count,
    input wire logic cmd_query_two,
    input wire logic cmd_wp_unlock,
    output logic cmd_ready,
    output logic data_take,
    output logic done,
    output logic fail,
    output logic [15:0] rdata,
    // flash pins
    input wire logic x8_mode_pin,
    input wire logic [15:0] flash_dq_in,
    output logic [ADDR_W-1:0] flash_addr,
    output logic [15:0] flash_dq_out,
    output logic flash_dq_oe_n,
    output logic flash_ce_n,
    output logic flash_rd_n,
    output logic flash_we_n,
    output logic flash_wp,
    output logic flash_rp_n
);

    localparam int BUF_AW = $clog2(BUF_WORDS);

    bus_cycle_if #(.ADDR_W(ADDR_W)) bus ();

    st_type state_r;
    op_type op_r;
    mode_type mode_r;
    logic [2:0] step_r;
    logic [ADDR_W-1:0] addr_r;
    logic [7:0] count_r;
    logic [8:0] words_r;
    logic two_r;
    logic x8_meta_r;
    logic x8_r;

    // ----------------------------------------------------------------
    // accept decode
    // ----------------------------------------------------------------
    wire accept = cmd_valid && cmd_ready;
    wire overflow = (cmd_op == OP_BUF_WRITE) &&
        ((9'(cmd_addr[BUF_AW-1:0]) + 9'(cmd_count)) >= 9'(BUF_WORDS));
    wire skip = (cmd_op == OP_READ_ARRAY) && (mode_r == MODE_ARRAY);
    wire resume_mode = (cmd_op == OP_READ_ID && mode_r == MODE_ID) ||
        (cmd_op == OP_QUERY && mode_r == MODE_QUERY);
    wire [2:0] start_step = resume_mode ? 3'h1 : 3'h0;
    wire wp_need = (cmd_op == OP_SET_LOCK) || (cmd_op == OP_CLEAR_LOCKS) || cmd_wp_unlock;
    wire mode_keep = (cmd_op == OP_READ) || (cmd_op == OP_CLEAR_STATUS);
    wire mode_type mode_nxt = (cmd_op == OP_READ_ARRAY) ? MODE_ARRAY :
        (cmd_op == OP_READ_ID) ? MODE_ID :
        (cmd_op == OP_QUERY) ? MODE_QUERY :
        mode_keep ? mode_r : MODE_STATUS;

    // ----------------------------------------------------------------
    // step table
    // ----------------------------------------------------------------
    logic s_write;
    logic s_is_data;
    logic s_end;
    logic [2:0] s_next;
    logic [7:0] s_code;
    wire step0 = (step_r == 3'h0);

    // each op as a command sequence
    always_comb begin
        s_write = 1'b1;
        s_is_data = 1'b0;
        s_end = 1'b0;
        s_next = step_r + 3'h1;
        s_code = CMD_READ_ARRAY;
        if (step_r == STEP_POLL) begin
            s_write = 1'b0;
            s_end = bus.rdata[READY_BIT];
            s_next = STEP_POLL;
        end else begin
            case (op_r)
                OP_READ: begin
                    s_write = 1'b0;
                    s_end = 1'b1;
                end
                OP_READ_ARRAY: s_end = 1'b1;
                OP_READ_ID: begin
                    s_code = CMD_READ_ID;
                    s_write = step0;
                    s_end = !step0;
                end
                OP_QUERY: begin
                    s_code = CMD_READ_QUERY;
                    s_write = step0;
                    s_end = (step_r == 3'h2) || (!step0 && !two_r);
                end
                OP_READ_STATUS: begin
                    s_code = CMD_READ_STATUS;
                    s_write = step0;
                    s_end = !step0;
                end
                OP_CLEAR_STATUS: begin
                    s_code = CMD_CLEAR_STATUS;
                    s_end = 1'b1;
                end
                OP_PROGRAM: begin
                    s_code = CMD_PROGRAM;
                    s_is_data = !step0;
                    if (!step0) s_next = STEP_POLL;
                end
                OP_BUF_WRITE: begin
                    case (step_r)
                        3'h0: s_code = CMD_BUF_WRITE;
                        3'h1: begin
                            s_write = 1'b0;
                            s_next = bus.rdata[READY_BIT] ? 3'h2 : 3'h0;
                        end
                        3'h2: s_code = count_r;
                        3'h3: begin
                            s_is_data = 1'b1;
                            s_next = (words_r == 9'(count_r) + 9'h001) ? 3'h4 : 3'h3;
                        end
                        default: begin
                            s_code = CMD_CONFIRM;
                            s_next = STEP_POLL;
                        end
                    endcase
                end
                OP_BLOCK_ERASE, OP_CHIP_ERASE: begin
                    s_code = step0 ? ((op_r == OP_BLOCK_ERASE) ? CMD_BLOCK_ERASE
                        : CMD_CHIP_ERASE) : CMD_CONFIRM;
                    if (!step0) s_next = STEP_POLL;
                end
                OP_SUSPEND: begin
                    s_code = CMD_SUSPEND;
                    s_next = STEP_POLL;
                end
                OP_RESUME: begin
                    s_code = CMD_CONFIRM;
                    s_end = 1'b1;
                end
                default: begin
                    s_code = step0 ? CMD_LOCK_SETUP :
                        (op_r == OP_SET_LOCK) ? CMD_LOCK_SET : CMD_CONFIRM;
                    if (!step0) s_next = STEP_POLL;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // address and data selection
    // ----------------------------------------------------------------
    // query word offset
    wire [ADDR_W-1:0] q_word = ADDR_W'(QUERY_BASE) + addr_r + ADDR_W'(step_r == 3'h2);
    wire [ADDR_W-1:0] q_addr = x8_r ? {q_word[ADDR_W-2:0], 1'b0} : q_word;
    wire [ADDR_W-1:0] buf_addr = addr_r + ADDR_W'(words_r);
    assign bus.req = (state_r == ST_ISSUE);
    assign bus.write = s_write;
    assign bus.addr = (op_r == OP_QUERY) ? q_addr :
        (op_r == OP_BUF_WRITE && step_r == 3'h3) ? buf_addr : addr_r;
    // defined codes and buffer count on low lane only
    assign bus.data = s_is_data ? cmd_data : {8'h00, s_code};

    // ----------------------------------------------------------------
    // strap synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            x8_meta_r <= 1'b0;
            x8_r <= 1'b0;
        end else begin
            x8_meta_r <= x8_mode_pin;
            x8_r <= x8_meta_r;
        end
    end

    // ----------------------------------------------------------------
    // operation sequencer
    // ----------------------------------------------------------------
    // array mode after reset
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r <= ST_IDLE;
            op_r <= OP_READ;
            mode_r <= RESET_MODE;
            step_r <= 3'h0;
            addr_r <= '0;
            count_r <= 8'h00;
            words_r <= 9'h000;
            two_r <= 1'b0;
            cmd_ready <= 1'b0;
            data_take <= 1'b0;
            done <= 1'b0;
            fail <= 1'b0;
            rdata <= 16'h0000;
            flash_wp <= 1'b0;
            flash_rp_n <= 1'b0;
        end else begin
            flash_rp_n <= 1'b1;
            data_take <= 1'b0;
            done <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    cmd_ready <= 1'b1;
                    if (accept) begin
                        cmd_ready <= 1'b0;
                        op_r <= cmd_op;
                        addr_r <= cmd_addr;
                        count_r <= cmd_count;
                        two_r <= cmd_query_two;
                        words_r <= 9'h000;
                        step_r <= start_step;
                        fail <= overflow;
                        flash_wp <= wp_need && !overflow && !skip;
                        if (!overflow) mode_r <= mode_nxt;
                        state_r <= (overflow || skip) ? ST_DONE : ST_ISSUE;
                    end
                end
                ST_ISSUE: begin
                    data_take <= s_is_data;
                    if (op_r == OP_BUF_WRITE && step_r == 3'h3) words_r <= words_r + 9'h001;
                    state_r <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (bus.done) begin
                        if (!s_write && op_r == OP_QUERY && step_r == 3'h2) begin
                            rdata[15:8] <= bus.rdata[7:0];
                        end else if (!s_write && op_r == OP_QUERY) begin
                            rdata <= {8'h00, bus.rdata[7:0]};
                        end else if (!s_write) begin
                            rdata <= bus.rdata;
                        end
                        step_r <= s_next;
                        state_r <= s_end ? ST_DONE : ST_ISSUE;
                    end
                end
                ST_DONE: begin
                    done <= 1'b1;
                    flash_wp <= 1'b0;
                    state_r <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    flash_bus_cycle #(.ADDR_W(ADDR_W)) u_cycle (
        .clk(clk),
        .reset(reset),
        .bus(bus.engine),
        .dq_in(flash_dq_in),
        .pin_addr(flash_addr),
        .pin_dq_out(flash_dq_out),
        .pin_dq_oe_n(flash_dq_oe_n),
        .pin_ce_n(flash_ce_n),
        .pin_rd_n(flash_rd_n),
        .pin_we_n(flash_we_n)
    );

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_cmd_upper_zero: assert property (
        @(posedge clk) disable iff (reset)
        bus.req && bus.write && !s_is_data |-> bus.data[15:8] == 8'h00)
        else $error("command write with nonzero upper byte");

    a_lock_needs_wp: assert property (
        @(posedge clk) disable iff (reset)
        bus.req && bus.write && !s_is_data && bus.data[7:0] == CMD_LOCK_SETUP |-> flash_wp)
        else $error("lock command issued with protect low");

    a_buf_confirm: assert property (
        @(posedge clk) disable iff (reset)
        bus.req && op_r == OP_BUF_WRITE && step_r == 3'h4
        |-> words_r == 9'(count_r) + 9'h001 && bus.data[7:0] == CMD_CONFIRM)
        else $error("confirm not after exactly count plus one words");

    a_query_low_byte: assert property (
        @(posedge clk) disable iff (reset)
        done && op_r == OP_QUERY && !two_r && !fail |-> rdata[15:8] == 8'h00)
        else $error("single query byte with nonzero upper byte");

    a_x8_query_even: assert property (
        @(posedge clk) disable iff (reset)
        bus.req && !bus.write && op_r == OP_QUERY && x8_r |-> bus.addr[0] == 1'b0)
        else $error("x8 query read at odd byte address");

endmodule : flash_host_ctrl

//--- tb/flash_device_model.sv
// Purpose: behavioural flash device seen from the host pins
// Assumes: operations finish at once, so status always reads ready
// Notes: released data lines show the inverse of the last value read
`timescale 1ns/100ps
module flash_device_model #(
    parameter logic [15:0] ID_CODE = 16'h0042 // arbitrary value
) (
    // flash pins
    input wire logic x8,
    input wire logic [21:0] addr,
    input wire logic [15:0] dq_out,
    input wire logic ce_n,
    input wire logic rd_n,
    input wire logic we_n,
    input wire logic rp_n,
    output logic [15:0] dq_in
);
    logic [1:0] mode = 2'h0; // array, id, query, status
    logic second = 1'b0;
    logic bufc = 1'b0;
    int left = 0;
    logic [15:0] last = 16'h0000;
    logic [15:0] rd_val;
    logic [7:0] c;
    logic [7:0] q;
    logic [21:0] wa;
    always @(negedge rp_n) mode = 2'h0;
    // low byte latched on strobe rise, arguments skipped
    always @(posedge we_n) if (!ce_n) begin
        c = dq_out[7:0];
        if (left > 0) left = left - 1;
        else if (bufc) begin
            bufc = 1'b0;
            left = int'(c) + 1;
        end else if (second) second = 1'b0;
        else begin
            mode = c == 8'hff ? 2'h0 : c == 8'h90 ? 2'h1 : c == 8'h98 ? 2'h2 : 2'h3;
            second = c inside {8'h40, 8'h10, 8'h20, 8'h30, 8'h60};
            bufc = c == 8'he8;
        end
    end
    // word offset, byte select ignored in x8
    assign wa = x8 ? addr >> 1 : addr;
    assign q = wa == 22'h10 ? 8'h51 : wa == 22'h11 ? 8'h52 : wa == 22'h12 ? 8'h59 :
               wa == 22'h13 ? 8'h01 : 8'h00;
    // query on low byte, status always ready
    assign rd_val = mode == 2'h0 ? addr[15:0] ^ 16'ha5a5 : mode == 2'h1 ? ID_CODE :
                    mode == 2'h2 ? {8'h00, q} : 16'h0080;
    always @(posedge rd_n) last = rd_val;
    assign dq_in = (!ce_n && !rd_n) ? rd_val : ~last;
endmodule : flash_device_model

//--- tb/tb.sv
// Purpose: self-checking bench of the flash host controller
// Assumes: device model answers every poll as ready
// Notes: expected results queued by the driver, checked on done
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
    $display("wrong value at %0t: got %h exp %h", $time, a, b); end end
module tb;
    import flash_host_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic cmd_valid = 1'b0;
    op_type cmd_op = OP_READ;
    logic [21:0] cmd_addr = 22'h0;
    logic [15:0] cmd_data = 16'h0;
    logic [7:0] cmd_count = 8'h0;
    logic cmd_query_two = 1'b0;
    logic cmd_wp_unlock = 1'b0;
    logic x8 = 1'b0;
    logic cmd_ready, data_take, done, fail, ce_n, rd_n, we_n, rp_n, wp, oe_n;
    logic exp_wp = 1'b0;
    logic [15:0] rdata, dq_in, dq_out;
    logic [21:0] fa;
    logic [32:0] exp_q[$];
    logic [32:0] e;
    logic [31:0] seed = 32'd25;
    int bad_count = 0;
    int cmp_count = 0;
    flash_host_ctrl #(.ADDR_W(22), .BUF_WORDS(16)) u_dut (.clk(clk), .reset(reset),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
        .cmd_count(cmd_count), .cmd_query_two(cmd_query_two), .cmd_wp_unlock(cmd_wp_unlock),
        .cmd_ready(cmd_ready), .data_take(data_take), .done(done), .fail(fail),
        .rdata(rdata), .x8_mode_pin(x8), .flash_dq_in(dq_in), .flash_addr(fa),
        .flash_dq_out(dq_out), .flash_dq_oe_n(oe_n), .flash_ce_n(ce_n), .flash_rd_n(rd_n),
        .flash_we_n(we_n), .flash_wp(wp), .flash_rp_n(rp_n));
    flash_device_model u_dev (.x8(x8), .addr(fa), .dq_out(dq_out), .ce_n(ce_n),
        .rd_n(rd_n), .we_n(we_n), .rp_n(rp_n), .dq_in(dq_in));
    initial forever #5 clk = ~clk;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    // next random word once the current one is taken
    always @(posedge clk) if (data_take === 1'b1) cmd_data <= 16'(xs());
    // take the oldest note whenever a result appears
    always @(posedge clk) if (done === 1'b1) begin
        e = exp_q.pop_front();
        `CHK({fail, rdata & e[31:16]}, {e[32], e[15:0]})
    end
    // every write strobe carries the expected protect level and a driven data bus
    always @(posedge we_n) if (ce_n === 1'b0) `CHK({wp, oe_n}, {exp_wp, 1'b0})
    // present one operation, note its result, wait for done
    task automatic op(op_type o, logic [21:0] a, logic [7:0] n, logic two, logic wp,
                      logic [15:0] m, logic [15:0] v, logic f);
        int k;
        exp_q.push_back({f, m, v});
        exp_wp = wp || (o == OP_SET_LOCK) || (o == OP_CLEAR_LOCKS);
        cmd_op <= o;
        cmd_addr <= a;
        cmd_count <= n;
        cmd_query_two <= two;
        cmd_wp_unlock <= wp;
        cmd_valid <= 1'b1;
        do @(posedge clk); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        for (k = 0; k < 4000 && done !== 1'b1; k++) @(posedge clk);
        if (done !== 1'b1) bad_count++;
        @(posedge clk);
    endtask : op
    task automatic do_reset(logic m);
        reset <= 1'b1;
        x8 <= m;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : do_reset
    task automatic finish_test();
        if (bad_count == 0 && cmp_count > 0 && exp_q.size() == 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : finish_test
    initial begin
        #200000;
        bad_count++;
        finish_test();
    end
    initial begin
        logic [21:0] a;
        static op_type lst[6] = '{OP_BLOCK_ERASE, OP_CHIP_ERASE, OP_SUSPEND, OP_RESUME,
                           OP_SET_LOCK, OP_CLEAR_LOCKS};
        do_reset(1'b0);
        a = 22'(xs());
        op(OP_READ, a, 0, 0, 0, 16'hffff, a[15:0] ^ 16'ha5a5, 0);
        op(OP_QUERY, 0, 0, 1, 0, 16'hffff, 16'h5251, 0);
        op(OP_QUERY, 2, 0, 0, 0, 16'hffff, 16'h0059, 0);
        op(OP_QUERY, 3, 0, 1, 0, 16'hffff, 16'h0001, 0);
        op(OP_READ_ID, 0, 0, 0, 0, 16'hffff, 16'h0042, 0);
        op(OP_READ_STATUS, 0, 0, 0, 0, 16'h00ff, 16'h0080, 0);
        op(OP_CLEAR_STATUS, 0, 0, 0, 0, 16'h00ff, 16'h0080, 0);
        op(OP_PROGRAM, 22'(xs()), 0, 0, 0, 16'h00ff, 16'h0080, 0);
        op(OP_BUF_WRITE, 22'h20, 8'h1, 0, 0, 16'h00ff, 16'h0080, 0);
        op(OP_BUF_WRITE, 22'h2f, 8'h0, 0, 0, 16'h00ff, 16'h0080, 0);
        op(OP_BUF_WRITE, 22'h0f, 8'h1, 0, 0, 16'h0000, 16'h0000, 1);
        foreach (lst[i]) op(lst[i], 22'(xs()), 0, 0, i < 2, 16'h0000, 16'h0000, 0);
        a = 22'(xs());
        op(OP_READ_ARRAY, a, 0, 0, 0, 16'h0000, 16'h0000, 0);
        op(OP_READ_ARRAY, a, 0, 0, 0, 16'h0000, 16'h0000, 0);
        op(OP_READ, a, 0, 0, 0, 16'hffff, a[15:0] ^ 16'ha5a5, 0);
        do_reset(1'b1);
        op(OP_QUERY, 0, 0, 1, 0, 16'hffff, 16'h5251, 0);
        op(OP_QUERY, 2, 0, 0, 0, 16'hffff, 16'h0059, 0);
        finish_test();
    end
endmodule : tb
